// file: include/addr_decode_pkg.sv
// Shared constants for the board address decoder and wait-state logic.
package addr_decode_pkg;

    localparam int ADDR_W = 20;
    localparam int CODE_W = 5;
    localparam int IO_DEV_N = 16;
    localparam int MEM_DEV_N = 6;
    localparam int DRAM_BANK_N = 4;
    localparam int WAIT_W = 3;
    localparam int IO_WAIT_MAX = 6;
    localparam int MEM_WAIT_MAX = 1;

    // Memory map in kilobyte units, the ROM area in 32 kilobyte units, taken from the upper address lines.
    localparam logic [9:0] DRAM_LIMIT_SMALL_KB = 10'h080;
    localparam logic [9:0] DRAM_LIMIT_BIG_KB = 10'h100;
    localparam logic [4:0] ROM_AREA_KB32 = 5'h1f;
    localparam logic [4:0] ROM_MIN_KB = 5'h02;

    // On-board I/O devices sit in one block of the I/O address lines, four ports each.
    localparam logic [3:0] IO_BLOCK_HI = 4'h0;
    localparam logic [3:0] IO_VECTOR_SEL_IDX = 4'hf;

    // Two-bit wait field per I/O device, device n in bits [2n+1:2n].
    localparam logic [31:0] IO_WAIT_TABLE = 32'he4000000;

    // Wait field codes and the clock counts they stand for.
    localparam logic [WAIT_W-1:0] WAIT_CNT_CODE0 = 3'h0;
    localparam logic [WAIT_W-1:0] WAIT_CNT_CODE1 = 3'h1;
    localparam logic [WAIT_W-1:0] WAIT_CNT_CODE2 = 3'h2;
    localparam logic [WAIT_W-1:0] WAIT_CNT_CODE3 = 3'h6;
    localparam logic [WAIT_W-1:0] MEM_SLOW_WAITS = 3'h1;
    localparam logic [WAIT_W-1:0] MEM_FAST_WAITS = 3'h0;

    // Compressed device codes: bit 4 set marks an I/O device.
    localparam logic [2:0] MEM_CODE_ROM0 = 3'h4;
    localparam logic [2:0] MEM_CODE_ROM1 = 3'h5;
    localparam logic IO_CODE_FLAG = 1'b1;

    // Reset values of the captured link settings.
    localparam logic STRAP_BIG_RST = 1'b0;
    localparam logic [1:0] STRAP_ROM_SIZE_RST = 2'h3;
    localparam logic STRAP_SLOW_EN_RST = 1'b0;
    localparam logic [9:0] STRAP_SLOW_KB_RST = 10'h000;

    typedef enum logic [1:0] {
        OWN_MAIN_CPU = 2'b00,
        OWN_ALT_CPU = 2'b01,
        OWN_DMA = 2'b10,
        OWN_OFFBOARD = 2'b11
    } bus_owner_e;

endpackage

// file: test/addr_decode_monitor.sv
// Concurrent checks on the decoder ports.
`timescale 1ns/1ns
`default_nettype none
module addr_decode_monitor (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Bus cycle.
    input wire logic [addr_decode_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_mem_cycle,
    input wire logic i_io_cycle,
    input wire logic i_cycle_start,
    input wire logic i_rd,
    input wire addr_decode_pkg::bus_owner_e i_owner,
    // Decode and ready.
    input wire logic [addr_decode_pkg::CODE_W-1:0] o_dev_code,
    input wire logic o_dev_code_valid,
    input wire logic [addr_decode_pkg::IO_DEV_N-1:0] o_io_sel,
    input wire logic [addr_decode_pkg::MEM_DEV_N-1:0] o_mem_sel,
    input wire logic o_option_bus_onboard_io_flag_b,
    input wire logic o_ready,
    // Parity, interrupt and refresh.
    input wire logic [8:0] i_dram_rdata,
    input wire logic i_dram_rd_check,
    input wire logic i_nmi_clear,
    input wire logic o_nmi,
    input wire logic i_dma_refresh_b,
    input wire logic o_refresh_strobe_b,
    input wire logic o_option_bus_refresh_strobe_b
);
    import addr_decode_pkg::*;
    logic [3:0] wait_run_q;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // Length of the current run of not-ready clocks.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_run_q <= 4'h0;
        end else begin
            wait_run_q <= o_ready ? 4'h0 : wait_run_q + 4'h1;
        end
    end
    sequence s_io_start;
        i_cycle_start && i_io_cycle && !i_mem_cycle && i_owner != OWN_OFFBOARD && i_addr[9:6] == 4'h0;
    endsequence
    sequence s_vec_start;
        i_cycle_start && i_io_cycle && !i_mem_cycle && i_owner != OWN_OFFBOARD && i_addr[9:2] == 8'h0f;
    endsequence
    sequence s_six_waits;
        !o_ready [*6] ##1 o_ready;
    endsequence
    AST_IO_DECODE: assert property (s_io_start |=> o_io_sel == 16'h1 << $past(i_addr[5:2]))
        else $error("io select does not match address");
    AST_VEC_WAIT: assert property (s_vec_start |=> s_six_waits)
        else $error("vector select wait length wrong");
    AST_WAIT_MAX: assert property (wait_run_q <= 4'h6)
        else $error("not-ready held too long");
    AST_ONEHOT: assert property ($onehot0(o_io_sel) && $onehot0(o_mem_sel))
        else $error("more than one select active");
    AST_IO_FLAG: assert property (o_option_bus_onboard_io_flag_b == !(|o_io_sel))
        else $error("on-board io flag disagrees with selects");
    AST_OFFBOARD_IO: assert property (i_cycle_start && i_io_cycle && i_owner == OWN_OFFBOARD
        |=> o_io_sel == 16'h0 && !o_dev_code_valid) else $error("off-board master granted io");
    AST_NMI_SET: assert property (i_dram_rd_check && o_dev_code_valid && o_dev_code < 5'h4 && i_rd
        && !(^i_dram_rdata) |=> o_nmi) else $error("parity error did not raise nmi");
    AST_NMI_HOLD: assert property (o_nmi && !i_nmi_clear |=> o_nmi)
        else $error("nmi dropped without clear");
    AST_NMI_CLEAR: assert property (o_nmi && i_nmi_clear && !i_dram_rd_check |=> !o_nmi)
        else $error("nmi not cleared");
    AST_REFRESH: assert property (o_refresh_strobe_b == $past(i_dma_refresh_b)
        && o_option_bus_refresh_strobe_b == o_refresh_strobe_b) else $error("refresh strobes wrong");
endmodule
bind address_decode_wait_states addr_decode_monitor mon (.*);
`default_nettype wire

// file: test/bus_owner_model.sv
// Bus owner model that runs memory and io cycles and counts wait clocks.
`timescale 1ns/1ns
`default_nettype none
module bus_owner_model (
    // Clock and ready.
    input wire logic i_core_clk,
    input wire logic i_ready,
    // Bus cycle.
    output logic [addr_decode_pkg::ADDR_W-1:0] o_addr,
    output logic o_mem_cycle,
    output logic o_io_cycle,
    output logic o_cycle_start,
    output logic o_cycle_active,
    output logic o_rd,
    output logic o_wr,
    output addr_decode_pkg::bus_owner_e o_owner
);
    import addr_decode_pkg::*;
    initial begin
        o_addr = 20'h0;
        {o_mem_cycle, o_io_cycle, o_cycle_start, o_cycle_active, o_rd, o_wr} = 6'h0;
        o_owner = OWN_MAIN_CPU;
    end
    // Opens a cycle and holds it until ready is seen high or twenty wait clocks have been counted.
    task automatic start_cycle(input logic [19:0] a, input logic io, input bus_owner_e own,
                               input logic rd, output int waits);
        @(negedge i_core_clk);
        o_addr = a;
        o_io_cycle = io;
        o_mem_cycle = !io;
        o_owner = own;
        o_rd = rd;
        o_wr = !rd;
        o_cycle_start = 1'b1;
        o_cycle_active = 1'b1;
        @(negedge i_core_clk);
        o_cycle_start = 1'b0;
        waits = 0;
        while (i_ready !== 1'b1 && waits < 20) begin
            waits++;
            @(negedge i_core_clk);
        end
    endtask
    // A released address bus shows no stale value.
    task automatic end_cycle();
        @(negedge i_core_clk);
        {o_mem_cycle, o_io_cycle, o_cycle_active, o_rd, o_wr} = 5'h0;
        o_addr = ~o_addr;
    endtask
endmodule
`default_nettype wire

// file: test/tb_address_decode_wait_states.sv
// Self-checking testbench for the address decoder and wait-state logic.
`timescale 1ns/1ns
`default_nettype none
module tb_address_decode_wait_states;
    import addr_decode_pkg::*;
    logic i_core_clk, i_rst_b, i_rd, i_wr, i_mem_cycle, i_io_cycle, i_cycle_start, i_cycle_active;
    logic [ADDR_W-1:0] i_addr;
    bus_owner_e i_owner;
    logic i_big_model_link, i_slow_range_en_link, i_dram_rd_check, i_nmi_clear, i_dma_refresh_b;
    logic [1:0] i_rom0_size_link, i_rom1_size_link;
    logic [9:0] i_slow_range_kb_link;
    logic [7:0] i_dram_wdata;
    logic [8:0] i_dram_rdata;
    logic [CODE_W-1:0] o_dev_code;
    logic [IO_DEV_N-1:0] o_io_sel;
    logic [MEM_DEV_N-1:0] o_mem_sel;
    logic o_dev_code_valid, o_option_bus_onboard_io_flag_b, o_xcvr_en, o_xcvr_inbound, o_ready;
    logic o_dram_wparity, o_nmi, o_refresh_strobe_b, o_option_bus_refresh_strobe_b;
    int num_errors = 0, cmp_count = 0, cycles = 0, w;
    address_decode_wait_states dut (.*);
    bus_owner_model mdl (.i_core_clk(i_core_clk), .i_ready(o_ready), .o_addr(i_addr), .o_mem_cycle(i_mem_cycle),
        .o_io_cycle(i_io_cycle), .o_cycle_start(i_cycle_start), .o_cycle_active(i_cycle_active),
        .o_rd(i_rd), .o_wr(i_wr), .o_owner(i_owner));
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    task automatic end_of_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic mem_cyc(input logic [19:0] a, input logic [5:0] es, input int ew);
        mdl.start_cycle(a, 1'b0, OWN_ALT_CPU, 1'b1, w);
        chk(w, ew);
        chk(o_mem_sel, es);
        chk(o_xcvr_en, es == 6'h0);
        mdl.end_cycle();
    endtask
    task automatic t_io();
        for (int d = 0; d < 16; d++) begin
            mdl.start_cycle({14'h0, d[3:0], 2'h0}, 1'b1, OWN_MAIN_CPU, 1'b1, w);
            chk(w, d == 15 ? 6 : d == 14 ? 2 : d == 13 ? 1 : 0);
            chk(o_io_sel, 16'h1 << d);
            chk(o_dev_code, {1'b1, d[3:0]});
            chk(o_option_bus_onboard_io_flag_b, 1'b0);
            chk(o_xcvr_en, 1'b0);
            chk(o_dev_code_valid, 1'b1);
            mdl.end_cycle();
        end
    endtask
    task automatic t_refused();
        mdl.start_cycle(20'h0000c, 1'b1, OWN_OFFBOARD, 1'b1, w);
        chk(o_io_sel, 16'h0);
        chk(o_option_bus_onboard_io_flag_b, 1'b1);
        chk(o_xcvr_en, 1'b0);
        mdl.end_cycle();
        mdl.start_cycle(20'h00040, 1'b1, OWN_MAIN_CPU, 1'b1, w);
        chk(o_dev_code_valid, 1'b0);
        chk(o_xcvr_en, 1'b1);
        chk(o_xcvr_inbound, 1'b1);
        mdl.end_cycle();
        mdl.start_cycle(20'h10000, 1'b0, OWN_OFFBOARD, 1'b0, w);
        chk(o_mem_sel, 6'h02);
        chk(o_xcvr_en, 1'b1);
        chk(o_xcvr_inbound, 1'b1);
        mdl.end_cycle();
    endtask
    task automatic t_mem();
        for (int m = 0; m < 2; m++) begin
            i_big_model_link = m[0];
            repeat (5) @(negedge i_core_clk);
            for (int b = 0; b < 4; b++) begin
                mem_cyc({2'h0, b[1:0], 16'h0}, (m == 1 || b < 2) ? 6'h1 << b : 6'h0, 0);
            end
        end
    endtask
    task automatic t_rom();
        mem_cyc(20'hfc000, 6'h10, 0);
        mem_cyc(20'hf8000, 6'h20, 0);
        i_rom0_size_link = 2'h0;
        repeat (5) @(negedge i_core_clk);
        mem_cyc(20'hfc7f0, 6'h10, 0);
        mem_cyc(20'hfc800, 6'h00, 0);
    endtask
    task automatic t_slow();
        i_slow_range_en_link = 1'b1;
        i_slow_range_kb_link = 10'h2a0;
        repeat (5) @(negedge i_core_clk);
        mem_cyc(20'ha8000, 6'h00, 1);
        mem_cyc(20'ha8400, 6'h00, 0);
    endtask
    task automatic pulse(input logic [8:0] rdat, input logic exp);
        @(negedge i_core_clk);
        i_dram_rdata = rdat;
        i_dram_rd_check = 1'b1;
        @(negedge i_core_clk);
        i_dram_rd_check = 1'b0;
        chk(o_nmi, exp);
    endtask
    task automatic t_parity();
        @(negedge i_core_clk);
        i_dram_wdata = 8'h03;
        @(negedge i_core_clk);
        chk(o_dram_wparity, 1'b1);
        i_dram_wdata = 8'h07;
        @(negedge i_core_clk);
        chk(o_dram_wparity, 1'b0);
        mdl.start_cycle(20'h00000, 1'b0, OWN_MAIN_CPU, 1'b1, w);
        pulse(9'h001, 1'b0);
        pulse(9'h003, 1'b1);
        pulse(9'h001, 1'b1);
        @(negedge i_core_clk);
        i_dram_rdata = 9'h003;
        i_dram_rd_check = 1'b1;
        i_nmi_clear = 1'b1;
        @(negedge i_core_clk);
        i_dram_rd_check = 1'b0;
        i_nmi_clear = 1'b0;
        chk(o_nmi, 1'b1);
        @(negedge i_core_clk);
        i_nmi_clear = 1'b1;
        @(negedge i_core_clk);
        i_nmi_clear = 1'b0;
        chk(o_nmi, 1'b0);
        mdl.end_cycle();
        mdl.start_cycle(20'h00000, 1'b0, OWN_MAIN_CPU, 1'b0, w);
        pulse(9'h003, 1'b0);
        mdl.end_cycle();
    endtask
    task automatic t_refresh();
        for (int v = 0; v < 2; v++) begin
            @(negedge i_core_clk);
            i_dma_refresh_b = v[0];
            @(negedge i_core_clk);
            chk(o_refresh_strobe_b, v[0]);
            chk(o_option_bus_refresh_strobe_b, v[0]);
        end
    endtask
    initial begin
        i_rst_b = 1'b0;
        i_big_model_link = 1'b0;
        i_rom0_size_link = 2'h3;
        i_rom1_size_link = 2'h3;
        i_slow_range_en_link = 1'b0;
        i_slow_range_kb_link = 10'h000;
        i_dram_wdata = 8'h00;
        i_dram_rdata = 9'h000;
        i_dram_rd_check = 1'b0;
        i_nmi_clear = 1'b0;
        i_dma_refresh_b = 1'b1;
        repeat (3) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        t_io();
        t_refused();
        t_mem();
        t_rom();
        t_slow();
        t_parity();
        t_refresh();
        end_of_test();
    end
endmodule
`default_nettype wire

// file: verilog/address_decode_wait_states.sv
// Main-board address decoder with wait-state insertion, DRAM parity and refresh routing.
`timescale 1ns/1ns
`default_nettype none
module address_decode_wait_states (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Bus cycle from the current owner.
    input wire logic [addr_decode_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_mem_cycle,
    input wire logic i_io_cycle,
    input wire logic i_cycle_start,
    input wire logic i_cycle_active,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire addr_decode_pkg::bus_owner_e i_owner,
    // Link settings from board pins.
    input wire logic i_big_model_link,
    input wire logic [1:0] i_rom0_size_link,
    input wire logic [1:0] i_rom1_size_link,
    input wire logic i_slow_range_en_link,
    input wire logic [9:0] i_slow_range_kb_link,
    // Device selection.
    output logic [addr_decode_pkg::CODE_W-1:0] o_dev_code,
    output logic o_dev_code_valid,
    output logic [addr_decode_pkg::IO_DEV_N-1:0] o_io_sel,
    output logic [addr_decode_pkg::MEM_DEV_N-1:0] o_mem_sel,
    output logic o_option_bus_onboard_io_flag_b,
    // Data transceiver control.
    output logic o_xcvr_en,
    output logic o_xcvr_inbound,
    // Processor ready.
    output logic o_ready,
    // DRAM data and parity.
    input wire logic [7:0] i_dram_wdata,
    input wire logic [8:0] i_dram_rdata,
    input wire logic i_dram_rd_check,
    output logic o_dram_wparity,
    // Non-maskable interrupt.
    input wire logic i_nmi_clear,
    output logic o_nmi,
    // Refresh.
    input wire logic i_dma_refresh_b,
    output logic o_refresh_strobe_b,
    output logic o_option_bus_refresh_strobe_b
);
    import addr_decode_pkg::*;

    localparam int STRAP_W = 16;
    // Sync stages start at the reset settings so no stray value is taken just after reset.
    localparam logic [STRAP_W-1:0] STRAP_RST = {STRAP_BIG_RST, STRAP_ROM_SIZE_RST, STRAP_ROM_SIZE_RST,
                                                STRAP_SLOW_EN_RST, STRAP_SLOW_KB_RST};

    // Link settings pass three flip-flops and are taken once stages two and three agree.
    logic [STRAP_W-1:0] strap_raw;
    logic [STRAP_W-1:0] strap_s1_q;
    logic [STRAP_W-1:0] strap_s2_q;
    logic [STRAP_W-1:0] strap_s3_q;
    logic cfg_big_q;
    logic [1:0] cfg_rom0_size_q;
    logic [1:0] cfg_rom1_size_q;
    logic cfg_slow_en_q;
    logic [9:0] cfg_slow_kb_q;

    assign strap_raw = {i_big_model_link, i_rom0_size_link, i_rom1_size_link,
                        i_slow_range_en_link, i_slow_range_kb_link};

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_s1_q <= STRAP_RST;
            strap_s2_q <= STRAP_RST;
            strap_s3_q <= STRAP_RST;
        end else begin
            strap_s1_q <= strap_raw;
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_big_q <= STRAP_BIG_RST;
            cfg_rom0_size_q <= STRAP_ROM_SIZE_RST;
            cfg_rom1_size_q <= STRAP_ROM_SIZE_RST;
            cfg_slow_en_q <= STRAP_SLOW_EN_RST;
            cfg_slow_kb_q <= STRAP_SLOW_KB_RST;
        end else if (strap_s2_q == strap_s3_q) begin
            {cfg_big_q, cfg_rom0_size_q, cfg_rom1_size_q, cfg_slow_en_q, cfg_slow_kb_q} <= strap_s3_q;
        end
    end

    // Memory decode from the kilobyte number on the upper address lines.
    wire [9:0] mem_kb = i_addr[19:10];
    wire [9:0] dram_limit_kb = cfg_big_q ? DRAM_LIMIT_BIG_KB : DRAM_LIMIT_SMALL_KB;
    wire dram_hit = (mem_kb < dram_limit_kb);
    wire [1:0] dram_bank = mem_kb[7:6];
    wire rom_area = (mem_kb[9:5] == ROM_AREA_KB32);
    wire rom_socket1 = !mem_kb[4];
    wire [1:0] rom_size_sel = rom_socket1 ? cfg_rom1_size_q : cfg_rom0_size_q;
    wire [4:0] rom_size_kb = 5'(ROM_MIN_KB << rom_size_sel);
    wire rom_hit = rom_area && ({1'b0, mem_kb[3:0]} < rom_size_kb);
    wire mem_hit = dram_hit || rom_hit;
    wire [2:0] mem_code = dram_hit ? {1'b0, dram_bank} : (rom_socket1 ? MEM_CODE_ROM1 : MEM_CODE_ROM0);
    wire slow_hit = cfg_slow_en_q && (mem_kb == cfg_slow_kb_q);

    // Ordinary memory needs no wait; only the chosen slow range takes one.
    wire [WAIT_W-1:0] mem_waits = slow_hit ? MEM_SLOW_WAITS : MEM_FAST_WAITS;

    // I/O decode from the low address lines; off-board masters are refused.
    wire [3:0] io_idx = i_addr[5:2];
    wire io_block = (i_addr[9:6] == IO_BLOCK_HI);
    wire io_hit = io_block && (i_owner != OWN_OFFBOARD);
    wire [1:0] io_wait_code = IO_WAIT_TABLE[{io_idx, 1'b0} +: 2];

    // The vector select port carries wait code three, which maps to six clocks.
    logic [WAIT_W-1:0] io_waits;
    always_comb begin
        unique case (io_wait_code)
            2'h0: io_waits = WAIT_CNT_CODE0;
            2'h1: io_waits = WAIT_CNT_CODE1;
            2'h2: io_waits = WAIT_CNT_CODE2;
            2'h3: io_waits = WAIT_CNT_CODE3;
        endcase
    end

    wire cycle_io = i_io_cycle && !i_mem_cycle;
    wire cycle_mem = i_mem_cycle && !i_io_cycle;
    wire hit_d = cycle_io ? io_hit : (cycle_mem && mem_hit);
    wire [CODE_W-1:0] code_d = cycle_io ? {IO_CODE_FLAG, io_idx} : {2'b00, mem_code};
    wire [WAIT_W-1:0] waits_d = cycle_io ? (io_hit ? io_waits : WAIT_CNT_CODE0) :
                                (cycle_mem ? mem_waits : WAIT_CNT_CODE0);
    wire offboard_owner = (i_owner == OWN_OFFBOARD);

    // Transceiver faces the option bus whenever the data leaves or enters the board.
    wire xcvr_en_d = offboard_owner ? hit_d : !hit_d;
    wire xcvr_inbound_d = offboard_owner ? i_wr : i_rd;

    // Decode result is caught early in the cycle and held until the cycle ends.
    logic [CODE_W-1:0] code_q;
    logic valid_q;
    logic is_io_q;
    logic xcvr_en_q;
    logic xcvr_inbound_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            code_q <= '0;
            valid_q <= 1'b0;
            is_io_q <= 1'b0;
            xcvr_en_q <= 1'b0;
            xcvr_inbound_q <= 1'b0;
        end else if (i_cycle_start) begin
            code_q <= code_d;
            valid_q <= hit_d;
            is_io_q <= cycle_io;
            xcvr_en_q <= xcvr_en_d && (cycle_io || cycle_mem);
            xcvr_inbound_q <= xcvr_inbound_d;
        end else if (!i_cycle_active) begin
            valid_q <= 1'b0;
            xcvr_en_q <= 1'b0;
        end
    end

    assign o_dev_code = code_q;
    assign o_dev_code_valid = valid_q;
    assign o_xcvr_en = xcvr_en_q;
    assign o_xcvr_inbound = xcvr_inbound_q;
    assign o_option_bus_onboard_io_flag_b = !(valid_q && is_io_q);

    // Secondary decoders expand the held code into one select per device.
    genvar gi;
    for (gi = 0; gi < IO_DEV_N; gi = gi + 1) begin : g_io_sel
        assign o_io_sel[gi] = valid_q && is_io_q && (code_q[3:0] == 4'(gi));
    end
    for (gi = 0; gi < MEM_DEV_N; gi = gi + 1) begin : g_mem_sel
        assign o_mem_sel[gi] = valid_q && !is_io_q && (code_q[2:0] == 3'(gi));
    end

    // Wait states are counted in processor clocks from the start of the cycle.
    wait_down_counter #(
        .WIDTH(WAIT_W)
    ) u_wait (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_load(i_cycle_start),
        .i_count(waits_d),
        .o_ready(o_ready)
    );

    // Parity check only counts on reads of an on-board DRAM bank.
    wire dram_read_sel = valid_q && !is_io_q && !code_q[2] && i_rd;

    dram_parity #(
        .DATA_W(8)
    ) u_parity (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_wdata(i_dram_wdata),
        .o_wparity(o_dram_wparity),
        .i_rd_check(i_dram_rd_check && dram_read_sel),
        .i_rdata(i_dram_rdata),
        .i_nmi_clear(i_nmi_clear),
        .o_nmi(o_nmi)
    );

    // Refresh strobe goes to both memories from one flip-flop each, same edge.
    logic refresh_b_q;
    logic option_refresh_b_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            refresh_b_q <= 1'b1;
            option_refresh_b_q <= 1'b1;
        end else begin
            refresh_b_q <= i_dma_refresh_b;
            option_refresh_b_q <= i_dma_refresh_b;
        end
    end

    assign o_refresh_strobe_b = refresh_b_q;
    assign o_option_bus_refresh_strobe_b = option_refresh_b_q;

    if (MEM_WAIT_MAX < 1 || IO_WAIT_MAX > (1 << WAIT_W) - 1) begin : g_check
        $error("wait counter too narrow for the largest wait count");
    end

    // The kilobyte and port split assumes a 20-bit bus.
    if (ADDR_W != 20) begin : g_check_addr
        $error("decoder needs a 20-bit address bus");
    end

    // Five code bits: one I/O flag and four device bits.
    if (CODE_W != 5) begin : g_check_code
        $error("decoder needs a 5-bit device code");
    end

    // Four I/O index bits give exactly sixteen selects.
    if (IO_DEV_N != 16) begin : g_check_io_n
        $error("decoder serves exactly sixteen I/O devices");
    end

    // Three memory code bits cover four banks and two sockets.
    if (MEM_DEV_N < 6 || MEM_DEV_N > 8) begin : g_check_mem_n
        $error("memory select count must lie between six and eight");
    end

    // The bank number is taken from two address bits.
    if (DRAM_BANK_N != 4) begin : g_check_banks
        $error("decoder serves exactly four DRAM banks");
    end

    // Four banks of 64K reach no further than 256 kilobytes.
    if (DRAM_LIMIT_BIG_KB > 10'h100 || DRAM_LIMIT_SMALL_KB > DRAM_LIMIT_BIG_KB) begin : g_check_dram
        $error("DRAM limits exceed the four banks");
    end

    // The largest part must fill exactly one 16 kilobyte socket window.
    if (int'(ROM_MIN_KB) * 8 != 16) begin : g_check_rom
        $error("ROM sizes do not fit the socket window");
    end

    // Socket codes sit above the banks and have bit two set, which the parity gate relies on.
    if (int'(MEM_CODE_ROM0) < DRAM_BANK_N || int'(MEM_CODE_ROM1) >= MEM_DEV_N
        || MEM_CODE_ROM0 == MEM_CODE_ROM1) begin : g_check_rom_code
        $error("ROM socket codes clash with the bank codes");
    end

    // Ordinary memory takes no wait and the slow range stays within the memory limit.
    if (MEM_FAST_WAITS != 3'h0 || int'(MEM_SLOW_WAITS) > MEM_WAIT_MAX) begin : g_check_mem_wait
        $error("memory wait counts outside their limits");
    end

    // Wait code three must give the I/O limit, and code two must lie below code three.
    if (int'(WAIT_CNT_CODE3) != IO_WAIT_MAX || WAIT_CNT_CODE2 >= WAIT_CNT_CODE3) begin : g_check_io_wait
        $error("I/O wait codes do not reach the six-clock limit");
    end

    // The vector select port must carry wait code three.
    if (IO_WAIT_TABLE[2 * int'(IO_VECTOR_SEL_IDX) +: 2] != 2'h3) begin : g_check_vector
        $error("vector select port lacks the longest wait");
    end

    // The captured settings vector must hold every link pin.
    if (STRAP_W != $bits({i_big_model_link, i_rom0_size_link, i_rom1_size_link,
                          i_slow_range_en_link, i_slow_range_kb_link})) begin : g_check_strap
        $error("link settings width does not match the link pins");
    end

endmodule
`default_nettype wire

// file: verilog/dram_parity.sv
// Parity generation on DRAM writes and checking on reads, raising the NMI.
`timescale 1ns/1ns
`default_nettype none
module dram_parity #(
    parameter int DATA_W = 8
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Write side.
    input wire logic [DATA_W-1:0] i_wdata,
    output logic o_wparity,
    // Read side.
    input wire logic i_rd_check,
    input wire logic [DATA_W:0] i_rdata,
    // Interrupt.
    input wire logic i_nmi_clear,
    output logic o_nmi
);

    logic nmi_q;
    logic par_err;

    if (DATA_W < 1) begin : g_check
        $error("dram_parity needs DATA_W of at least one");
    end

    // Odd parity: the stored word always holds an odd count of ones.
    assign o_wparity = ~(^i_wdata);
    assign par_err = i_rd_check && !(^i_rdata);
    assign o_nmi = nmi_q;

    // A new error wins over a clear in the same cycle.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            nmi_q <= 1'b0;
        end else if (par_err) begin
            nmi_q <= 1'b1;
        end else if (i_nmi_clear) begin
            nmi_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: verilog/wait_down_counter.sv
// Down counter that holds the processor not-ready for a loaded number of clocks.
`timescale 1ns/1ns
`default_nettype none
module wait_down_counter #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Load request and count.
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    // Processor ready.
    output logic o_ready
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    if (WIDTH < 1) begin : g_check
        $error("wait_down_counter needs WIDTH of at least one");
    end

    // Each clock with a nonzero count is one wait state.
    assign count_d = i_load ? i_count : ((count_q != '0) ? count_q - 1'b1 : count_q);
    assign o_ready = (count_q == '0);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule
`default_nettype wire
